/* logic/iss_pkg.sv */
// shared constants and types for the impedance sweep sequencer
package iss_pkg;
    // dds and datapath widths
    localparam int PHASE_W = 27;
    localparam int CODE_W = 24;
    localparam int POINT_W = 9;
    localparam int SAMPLE_W = 12;
    localparam int ACC_W = 22;
    localparam int OUT_W = 8;
    // byte register locations
    localparam logic [7:0] REG_CTRL_HI = 8'h80;
    localparam logic [7:0] REG_CTRL_LO = 8'h81;
    localparam logic [7:0] REG_START_HI = 8'h82;
    localparam logic [7:0] REG_START_MID = 8'h83;
    localparam logic [7:0] REG_START_LO = 8'h84;
    localparam logic [7:0] REG_STEP_HI = 8'h85;
    localparam logic [7:0] REG_STEP_MID = 8'h86;
    localparam logic [7:0] REG_STEP_LO = 8'h87;
    localparam logic [7:0] REG_COUNT_HI = 8'h88;
    localparam logic [7:0] REG_COUNT_LO = 8'h89;
    localparam logic [7:0] REG_SETTLE_HI = 8'h8a;
    localparam logic [7:0] REG_SETTLE_LO = 8'h8b;
    localparam logic [7:0] REG_STATUS = 8'h8f;
    localparam logic [7:0] REG_REAL_HI = 8'h94;
    localparam logic [7:0] REG_REAL_LO = 8'h95;
    localparam logic [7:0] REG_IMAG_HI = 8'h96;
    localparam logic [7:0] REG_IMAG_LO = 8'h97;
    // control field positions within the 16-bit control word, status flag bits within the status byte
    localparam int CTRL_CMD_LSB = 12;
    localparam int CTRL_RANGE_LSB = 9;
    localparam int CTRL_CLKSEL_BIT = 3;
    localparam int STAT_POINT_BIT = 2;
    localparam int STAT_SWEEP_BIT = 3;
    // command codes in control bits 15..12
    localparam logic [3:0] CMD_INIT = 4'h1;
    localparam logic [3:0] CMD_START = 4'h2;
    localparam logic [3:0] CMD_INC = 4'h3;
    localparam logic [3:0] CMD_REPEAT = 4'h4;
    localparam logic [3:0] CMD_POWERDOWN = 4'ha;
    localparam logic [3:0] CMD_STANDBY = 4'hb;
    // values after reset, and the default device address
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [23:0] CODE_RESET = 24'h000000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h0d;
    // timing
    localparam int CORE_CLK_KHZ = 200000;
    localparam int INT_OSC_KHZ = 16776;
    localparam int OSC_DIV = CORE_CLK_KHZ / INT_OSC_KHZ;
    localparam int DDS_DIV = 4;
    localparam int MEAS_TICKS = 1024;
    // sequencer modes
    typedef enum logic [2:0] {
        M_POWERDOWN,
        M_STANDBY,
        M_INIT,
        M_SETTLE,
        M_MEASURE,
        M_HOLD
    } iss_mode_t;
    // serial slave phases
    typedef enum logic [2:0] {
        P_IDLE,
        P_ADDR,
        P_WRITE,
        P_ACK_TX,
        P_READ,
        P_ACK_RX
    } iss_phase_t;
endpackage

/* logic/iss_phase_acc.sv */
// dds phase accumulator with wrap pulse
module iss_phase_acc #(
    parameter int WIDTH = 27
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [WIDTH-1:0] code_i,
    output logic [WIDTH-1:0] phase_o,
    output logic wrap_o
);
    import iss_pkg::*;

    logic [WIDTH:0] next_sum;

    // carry out marks one output cycle elapsed
    assign next_sum = {1'b0, phase_o} + {1'b0, code_i};

    // phase steps once per update tick
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_o <= '0;
            wrap_o <= 1'b0;
        end else if (clear_i) begin
            phase_o <= '0;
            wrap_o <= 1'b0;
        end else begin
            wrap_o <= tick_i & next_sum[WIDTH];
            if (tick_i) begin
                phase_o <= next_sum[WIDTH-1:0];
            end
        end
    end

    phase_step_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (tick_i && !clear_i) |=> phase_o == WIDTH'($past(phase_o) + $past(code_i)))
        else $error("phase did not advance by code");
    phase_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (!tick_i && !clear_i) |=> $stable(phase_o))
        else $error("phase moved without a tick");
endmodule // iss_phase_acc

/* logic/iss_sweep_core.sv */
// impedance sweep sequencer with serial register port and dds control
import iss_pkg::*;

// Overview of operation
// - excitation from 27-bit phase accumulator
// - start code top three bits forced zero
// - start code 24 bits, MSB at 0x82
// - step code 24 bits at 0x85..0x87
// - point count nine bits, max 511
// - sweep begins only on start command
// - status D2 set when point done
// - results placed at 0x94 and 0x96
// - advance only on increment command
// - repeat remeasures current point, no step
// - D3 on sweep end blocks increments
// - standby grounds output and input
// - initialize excites start frequency, no measure
// - settling output cycles before sampling
// - D10..D9 select four output ranges
// - control D3 picks external or internal
// - results 16-bit twos complement
// - internal oscillator selected after reset
module iss_sweep_core #(
    parameter logic [6:0] DEV_ADDR = iss_pkg::DEV_ADDR_DEF
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic ext_clk_i,
    input wire logic signed [iss_pkg::SAMPLE_W-1:0] rx_sample_i,
    output logic [iss_pkg::OUT_W-1:0] excitation_output_o,
    output logic [1:0] excitation_range_o,
    output logic receive_grounded_o,
    output logic measuring_o
);
    import iss_pkg::*;

    // serial slave state
    iss_phase_t ph;
    logic scl_q, sda_q, rd_mode, ptr_pending;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, reg_ptr, rd_byte;
    // register file
    logic [15:0] ctrl, settle_count, result_real, result_imag;
    logic [CODE_W-1:0] start_code, step_code;
    logic [POINT_W-1:0] point_count, point_idx, settle_cnt;
    logic pt_done, sweep_done;
    // sequencer state
    iss_mode_t mode;
    logic [PHASE_W-1:0] freq_code, phase;
    logic [10:0] meas_cnt;
    logic signed [ACC_W-1:0] acc_re, acc_im, next_acc_re, next_acc_im, samp;
    logic ext_q, wrap;
    logic [3:0] osc_cnt;
    logic [1:0] div_cnt;
    logic [OUT_W-1:0] next_out;

    // bus edge and condition detection
    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_cond = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_cond = scl_i & scl_q & ~sda_q & sda_i;
    wire [7:0] rx_byte = {shreg[6:0], sda_i};
    wire byte_done = scl_rise && bit_cnt == 4'h7 && (ph == P_ADDR || ph == P_WRITE);
    wire addr_hit = rx_byte[7:1] == DEV_ADDR;
    wire wr_stb = byte_done && ph == P_WRITE && !ptr_pending;
    wire [7:0] wr_addr = reg_ptr;
    wire [7:0] wr_data = rx_byte;

    // open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = (ph == P_ACK_TX) || (ph == P_READ && !shreg[7]);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ext_q <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            ext_q <= ext_clk_i;
        end
    end

    // byte-level slave: sample on scl rise, drive on scl fall
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph <= P_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            ptr_pending <= 1'b0;
            reg_ptr <= 8'h00;
        end else if (start_cond) begin
            ph <= P_ADDR;
            bit_cnt <= 4'h0;
        end else if (stop_cond) begin
            ph <= P_IDLE;
        end else begin
            case (ph)
                P_ADDR, P_WRITE: begin
                    if (scl_rise) begin
                        shreg <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done && ph == P_ADDR) begin
                        rd_mode <= rx_byte[0];
                        ptr_pending <= ~rx_byte[0];
                        if (!addr_hit) ph <= P_IDLE; // not ours: ignore to stop
                    end
                    if (byte_done && ph == P_WRITE) begin
                        ptr_pending <= 1'b0;
                        reg_ptr <= ptr_pending ? rx_byte : reg_ptr + 8'h01;
                    end
                    if (scl_fall && bit_cnt == 4'h8) ph <= P_ACK_TX;
                end
                P_ACK_TX: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        ph <= rd_mode ? P_READ : P_WRITE;
                        if (rd_mode) begin
                            shreg <= rd_byte;
                            reg_ptr <= reg_ptr + 8'h01;
                        end
                    end
                end
                P_READ: begin
                    if (scl_rise) bit_cnt <= bit_cnt + 4'h1;
                    if (scl_fall && bit_cnt == 4'h8) ph <= P_ACK_RX;
                    else if (scl_fall) shreg <= {shreg[6:0], 1'b0};
                end
                P_ACK_RX: begin
                    if (scl_rise && sda_i) ph <= P_IDLE; // master nack ends the read
                    else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        ph <= P_READ;
                        shreg <= rd_byte;
                        reg_ptr <= reg_ptr + 8'h01;
                    end
                end
                default: ph <= P_IDLE;
            endcase
        end
    end

    // read decode; unmapped locations read as zero
    always_comb begin
        if (reg_ptr == REG_CTRL_HI) rd_byte = ctrl[15:8];
        else if (reg_ptr == REG_CTRL_LO) rd_byte = ctrl[7:0];
        else if (reg_ptr == REG_START_HI) rd_byte = start_code[23:16];
        else if (reg_ptr == REG_START_MID) rd_byte = start_code[15:8];
        else if (reg_ptr == REG_START_LO) rd_byte = start_code[7:0];
        else if (reg_ptr == REG_STEP_HI) rd_byte = step_code[23:16];
        else if (reg_ptr == REG_STEP_MID) rd_byte = step_code[15:8];
        else if (reg_ptr == REG_STEP_LO) rd_byte = step_code[7:0];
        else if (reg_ptr == REG_COUNT_HI) rd_byte = {7'h00, point_count[8]};
        else if (reg_ptr == REG_COUNT_LO) rd_byte = point_count[7:0];
        else if (reg_ptr == REG_SETTLE_HI) rd_byte = settle_count[15:8];
        else if (reg_ptr == REG_SETTLE_LO) rd_byte = settle_count[7:0];
        else if (reg_ptr == REG_STATUS) rd_byte = {4'h0, sweep_done, pt_done, 2'b00};
        else if (reg_ptr == REG_REAL_HI) rd_byte = result_real[15:8];
        else if (reg_ptr == REG_REAL_LO) rd_byte = result_real[7:0];
        else if (reg_ptr == REG_IMAG_HI) rd_byte = result_imag[15:8];
        else if (reg_ptr == REG_IMAG_LO) rd_byte = result_imag[7:0];
        else rd_byte = 8'h00;
    end

    // host-writable parameter bytes, most significant byte first
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl <= CTRL_RESET;
            start_code <= CODE_RESET;
            step_code <= CODE_RESET;
            point_count <= '0;
            settle_count <= WORD_RESET;
        end else if (wr_stb) begin
            if (wr_addr == REG_CTRL_HI) ctrl[15:8] <= wr_data;
            else if (wr_addr == REG_CTRL_LO) ctrl[7:0] <= wr_data;
            else if (wr_addr == REG_START_HI) start_code[23:16] <= wr_data;
            else if (wr_addr == REG_START_MID) start_code[15:8] <= wr_data;
            else if (wr_addr == REG_START_LO) start_code[7:0] <= wr_data;
            else if (wr_addr == REG_STEP_HI) step_code[23:16] <= wr_data;
            else if (wr_addr == REG_STEP_MID) step_code[15:8] <= wr_data;
            else if (wr_addr == REG_STEP_LO) step_code[7:0] <= wr_data;
            else if (wr_addr == REG_COUNT_HI) point_count[8] <= wr_data[0];
            else if (wr_addr == REG_COUNT_LO) point_count[7:0] <= wr_data;
            else if (wr_addr == REG_SETTLE_HI) settle_count[15:8] <= wr_data;
            else if (wr_addr == REG_SETTLE_LO) settle_count[7:0] <= wr_data;
        end
    end

    // command decode from the control high byte
    wire cmd_wr = wr_stb && wr_addr == REG_CTRL_HI;
    wire [3:0] cmd = wr_data[7:4];
    wire start_ok = cmd_wr && cmd == CMD_START;
    wire inc_ok = cmd_wr && cmd == CMD_INC && mode == M_HOLD && !sweep_done;
    wire rep_ok = cmd_wr && cmd == CMD_REPEAT && mode == M_HOLD;
    wire [PHASE_W-1:0] start_ext = {3'b000, start_code};
    wire [PHASE_W-1:0] step_ext = {3'b000, step_code};

    // update tick: selected system clock divided by four
    wire osc_tick = osc_cnt == 4'(OSC_DIV - 1);
    wire sys_tick = ctrl[CTRL_CLKSEL_BIT] ? (ext_clk_i & ~ext_q) : osc_tick;
    wire dds_run = mode != M_POWERDOWN && mode != M_STANDBY;
    wire dds_tick = sys_tick && div_cnt == 2'(DDS_DIV - 1);
    wire settle_hit = settle_cnt >= settle_count[8:0];
    wire meas_end = mode == M_MEASURE && dds_tick && meas_cnt == 11'(MEAS_TICKS - 1);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_cnt <= 4'h0;
            div_cnt <= 2'b00;
        end else begin
            osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
            if (sys_tick) div_cnt <= div_cnt + 2'b01;
        end
    end

    iss_phase_acc #(.WIDTH(PHASE_W)) u_acc (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(!dds_run),
        .tick_i(dds_tick && dds_run),
        .code_i(freq_code),
        .phase_o(phase),
        .wrap_o(wrap)
    );

    // mode, point index and active frequency code
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode <= M_POWERDOWN;
            point_idx <= '0;
            freq_code <= '0;
        end else if (cmd_wr && cmd == CMD_STANDBY) begin
            mode <= M_STANDBY;
        end else if (cmd_wr && cmd == CMD_POWERDOWN) begin
            mode <= M_POWERDOWN;
        end else if (cmd_wr && cmd == CMD_INIT) begin
            mode <= M_INIT;
            freq_code <= start_ext;
        end else if (start_ok) begin
            mode <= M_SETTLE;
            point_idx <= '0;
            freq_code <= start_ext;
        end else if (inc_ok) begin
            mode <= M_SETTLE;
            point_idx <= point_idx + 9'h001;
            freq_code <= freq_code + step_ext;
        end else if (rep_ok) begin
            mode <= M_SETTLE;
        end else if (mode == M_SETTLE && settle_hit) begin
            mode <= M_MEASURE;
        end else if (meas_end) begin
            mode <= M_HOLD;
        end
    end

    // quadrature accumulation against the dds phase
    assign samp = ACC_W'(rx_sample_i);
    assign next_acc_re = (phase[26] ^ phase[25]) ? acc_re - samp : acc_re + samp;
    assign next_acc_im = phase[26] ? acc_im + samp : acc_im - samp;

    // settling counts whole output cycles, then a fixed sample window
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_cnt <= '0;
            meas_cnt <= 11'h000;
            acc_re <= '0;
            acc_im <= '0;
        end else if (mode != M_SETTLE && mode != M_MEASURE) begin
            settle_cnt <= '0;
        end else if (mode == M_SETTLE) begin
            meas_cnt <= 11'h000;
            acc_re <= '0;
            acc_im <= '0;
            if (wrap && !settle_hit) settle_cnt <= settle_cnt + 9'h001;
        end else if (dds_tick) begin
            meas_cnt <= meas_cnt + 11'h001;
            acc_re <= next_acc_re;
            acc_im <= next_acc_im;
        end
    end

    // results and status flags; start clears both flags in any mode except on meas_end, increment and repeat clear only the point flag while holding
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pt_done <= 1'b0;
            sweep_done <= 1'b0;
            result_real <= WORD_RESET;
            result_imag <= WORD_RESET;
        end else if (meas_end) begin
            pt_done <= 1'b1;
            sweep_done <= point_idx >= point_count;
            result_real <= next_acc_re[ACC_W-1:ACC_W-16];
            result_imag <= next_acc_im[ACC_W-1:ACC_W-16];
        end else if (start_ok || inc_ok || rep_ok) begin
            pt_done <= 1'b0;
            sweep_done <= sweep_done & ~start_ok;
        end
    end

    // excitation: triangle from phase, attenuated per range
    assign next_out = (phase[26] ? ~phase[25:18] : phase[25:18]) >> ctrl[10:9];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) excitation_output_o <= '0;
        else excitation_output_o <= dds_run ? next_out : '0;
    end

    assign excitation_range_o = ctrl[CTRL_RANGE_LSB +: 2];
    assign receive_grounded_o = mode == M_STANDBY;
    assign measuring_o = mode == M_MEASURE;

    sequence inc_seq;
        inc_ok ##1 (mode == M_SETTLE);
    endsequence

    // only the loaded start code is masked; later steps may carry into the top bits
    start_mask_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (start_ok || (cmd_wr && cmd == CMD_INIT))
        |=> freq_code == {3'b000, $past(start_code)})
        else $error("start code top bits not forced to zero");
    point_flag_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        meas_end |=> pt_done && mode == M_HOLD)
        else $error("point done flag not set after measurement");
    result_load_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        meas_end |=> result_real == $past(next_acc_re[21:6]))
        else $error("real result not loaded");
    no_self_step_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !cmd_wr |=> $stable(freq_code) && $stable(point_idx))
        else $error("frequency stepped without command");
    inc_step_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        inc_seq |-> freq_code == $past(freq_code) + step_ext)
        else $error("increment did not add step code");
    repeat_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        rep_ok |=> $stable(freq_code) && mode == M_SETTLE && !pt_done)
        else $error("repeat changed frequency");
    done_block_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (sweep_done && mode == M_HOLD && cmd_wr && cmd == CMD_INC) |=> $stable(point_idx))
        else $error("increment accepted after sweep end");
    standby_gnd_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == M_STANDBY)[*2] |-> excitation_output_o == '0 && receive_grounded_o)
        else $error("standby not grounded");
    init_quiet_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        mode == M_INIT |-> !measuring_o && freq_code == start_ext)
        else $error("measuring or wrong code in initialize");
    settle_first_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ($past(mode) == M_SETTLE && mode == M_MEASURE) |-> $past(settle_hit))
        else $error("sampling before settling cycles elapsed");
    sweep_start_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ($past(mode) != M_SETTLE && $past(mode) != M_HOLD && mode == M_SETTLE)
        |-> $past(start_ok))
        else $error("sweep began without start command");
endmodule // iss_sweep_core

/* test/iss_host_model.sv */
// two-wire host model that drives the sequencer's register port
module iss_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h0d
) (
    input wire logic core_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_drive_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int nacks = 0;
    // bus idles released, pull-ups hold both lines high
    initial begin
        scl_o = 1'b1;
        sda_drive_o = 1'b1;
    end
    // four core cycles a phase, four times the shortest the port accepts
    task automatic half();
        repeat (4) @(negedge core_clk_i);
    endtask
    // data set while scl low, line sampled at the end of the high phase
    task automatic pulse(input logic d, output logic r);
        sda_drive_o = d;
        half();
        scl_o = 1'b1;
        half();
        r = sda_line_i;
        scl_o = 1'b0;
    endtask
    // start is cond(1,0,0), stop is cond(0,1,1)
    task automatic cond(input logic a, input logic z, input logic s);
        sda_drive_o = a;
        half();
        scl_o = 1'b1;
        half();
        sda_drive_o = z;
        half();
        scl_o = s;
    endtask
    task automatic send(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(v[i], r);
        pulse(1'b1, r);
        if (r) nacks++;
    endtask
    // msb of every multi-byte value at the lowest location
    task automatic write_seq(input logic [7:0] p, input int n, input logic [23:0] d);
        cond(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR, 1'b0});
        send(p);
        for (int k = n - 1; k >= 0; k--) send(d[k*8+:8]);
        cond(1'b0, 1'b1, 1'b1);
    endtask
    // last byte is refused with a released ack so the port stops sending
    task automatic read_seq(input logic [7:0] p, input int n, output logic [23:0] d);
        logic [7:0] v;
        logic r;
        d = '0;
        cond(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR, 1'b0});
        send(p);
        cond(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR, 1'b1});
        for (int k = n - 1; k >= 0; k--) begin
            for (int i = 7; i >= 0; i--) pulse(1'b1, v[i]);
            pulse(k == 0, r);
            d = {d[15:0], v};
        end
        cond(1'b0, 1'b1, 1'b1);
    endtask
    task automatic write_byte(input logic [7:0] p, input logic [7:0] v);
        write_seq(p, 1, {16'h0000, v});
    endtask
    task automatic write_code(input logic [7:0] p, input logic [23:0] v);
        write_seq(p, 3, v);
    endtask
    task automatic read_byte(input logic [7:0] p, output logic [7:0] v);
        logic [23:0] d;
        read_seq(p, 1, d);
        v = d[7:0];
    endtask
    task automatic read_code(input logic [7:0] p, output logic [23:0] v);
        read_seq(p, 3, v);
    endtask
endmodule // iss_host_model

/* test/test_impedance_sweep_sequencer.sv */
// self-checking bench: host transactions against the sweep sequencer
module test_impedance_sweep_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import iss_pkg::*;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ext_clk = 1'b0;
    logic signed [SAMPLE_W-1:0] rx = '0;
    logic scl, sda_drv, sda_o, sda_oe, grounded, measuring;
    logic [OUT_W-1:0] exc;
    logic [1:0] range;
    logic [7:0] b;
    logic [23:0] c;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire sda_line;
    // open drain: pulled high unless someone pulls low
    assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
    iss_sweep_core i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .ext_clk_i(ext_clk),
        .rx_sample_i(rx), .excitation_output_o(exc), .excitation_range_o(range),
        .receive_grounded_o(grounded), .measuring_o(measuring));
    iss_host_model i_host (.core_clk_i(core_clk_i), .sda_line_i(sda_line), .scl_o(scl),
        .sda_drive_o(sda_drv));
    always #2.5 core_clk_i = ~core_clk_i;
    // fast reference clock keeps each 1024-tick measurement short
    always @(negedge core_clk_i) begin
        ext_clk <= ~ext_clk;
        rx <= rx + 12'sh135;
    end
    // watchdog, three measurements need about 25000 cycles, the whole run about 35000
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end
    task automatic check_reg(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] k, input logic [1:0] r);
        i_host.write_byte(REG_CTRL_HI, {k, 1'b0, r, 1'b0});
    endtask
    // poll until the point-done flag shows, bounded
    task automatic wait_point();
        b = 8'h00;
        for (int i = 0; i < 60 && b[STAT_POINT_BIT] !== 1'b1; i++) begin
            i_host.read_byte(REG_STATUS, b);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        check_pin({4'h0, grounded, measuring, range}, 8'h00);
        check_pin(exc, 8'h00);
        i_host.read_byte(REG_STATUS, b);
        check_reg({16'h0, b}, 24'h0);
        i_host.read_byte(REG_CTRL_LO, b);
        check_reg({16'h0, b}, 24'h0);
        // top code wraps every eight ticks so settling stays short
        i_host.write_code(REG_START_HI, 24'hffffff);
        i_host.read_code(REG_START_HI, c);
        check_reg(c, 24'hffffff);
        i_host.write_code(REG_STEP_HI, 24'h00014f);
        i_host.read_code(REG_STEP_HI, c);
        check_reg(c, 24'h00014f);
        i_host.write_byte(REG_COUNT_LO, 8'h01);
        i_host.write_byte(REG_SETTLE_LO, 8'h02);
        i_host.read_code(REG_COUNT_HI, c);
        check_reg(c, 24'h000100);
        i_host.read_byte(8'h90, b);
        check_reg({16'h0, b}, 24'h0);
        for (int r = 0; r < 4; r++) begin
            cmd(CMD_STANDBY, r[1:0]);
            check_pin({6'h0, range}, r[7:0]);
            check_pin({7'h0, grounded}, 8'h01);
            check_pin(exc, 8'h00);
        end
        cmd(CMD_INIT, 2'b00);
        c = 24'h0;
        repeat (300) begin
            @(negedge core_clk_i);
            c = c | {16'h0, exc};
            if (measuring !== 1'b0) c[23] = 1'b1;
        end
        check_reg({c[23], 22'h0, |c[7:0]}, 24'h000001);
        // initialize ran on the internal oscillator; the sweep uses the reference pin
        i_host.write_byte(REG_CTRL_LO, 8'h08);
        cmd(CMD_START, 2'b00);
        repeat (40) @(negedge core_clk_i);
        check_pin({7'h0, measuring}, 8'h00);
        repeat (400) @(negedge core_clk_i);
        check_pin({7'h0, measuring}, 8'h01);
        wait_point();
        check_reg({16'h0, b}, 24'h000004);
        i_host.read_byte(REG_REAL_HI, b);
        i_host.read_byte(REG_IMAG_HI, b);
        repeat (1500) @(negedge core_clk_i);
        check_pin({7'h0, measuring}, 8'h00);
        cmd(CMD_INC, 2'b00);
        wait_point();
        check_reg({16'h0, b}, 24'h00000c);
        cmd(CMD_INC, 2'b00);
        repeat (400) @(negedge core_clk_i);
        check_pin({7'h0, measuring}, 8'h00);
        cmd(CMD_REPEAT, 2'b00);
        repeat (400) @(negedge core_clk_i);
        check_pin({7'h0, measuring}, 8'h01);
        wait_point();
        check_reg({16'h0, b}, 24'h00000c);
        check_reg(24'(i_host.nacks), 24'h0);
        finish_test();
    end
endmodule // test_impedance_sweep_sequencer
